// [common/cdc_pkg.sv]
package cdc_pkg;
    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] CDC_ADDR_CTRL0_C1 = 8'h00;
    localparam logic [7:0] CDC_ADDR_CTRL1_C1 = 8'h04;
    localparam logic [7:0] CDC_ADDR_CTRL0_C2 = 8'h08;
    localparam logic [7:0] CDC_ADDR_CTRL1_C2 = 8'h0C;
    localparam logic [7:0] CDC_ADDR_MIRROR = 8'h10;
    localparam logic [7:0] CDC_ADDR_FLAGS = 8'h14;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CDC_B_ENABLE = 7;
    localparam int CDC_B_RESULT = 6;
    localparam int CDC_B_PIN_DRIVE = 5;
    localparam int CDC_B_INVERT = 4;
    localparam int CDC_B_SPEED = 2;
    localparam int CDC_B_HYST = 1;
    localparam int CDC_B_SYNC = 0;
    localparam int CDC_B_RISE_EN = 7;
    localparam int CDC_B_FALL_EN = 6;
    localparam int CDC_B_POS_LO = 4;
    localparam int CDC_B_NEG_LO = 0;
    // ****************************************
    // reset values and writable masks
    // ****************************************
    localparam logic [7:0] CDC_RST_CTRL0 = 8'h04;
    localparam logic [7:0] CDC_RST_CTRL1 = 8'h00;
    localparam logic [7:0] CDC_WMASK_CTRL0 = 8'hB7;
    localparam logic [7:0] CDC_WMASK_CTRL1 = 8'hF3;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        CDC_POS_PIN = 2'b00,
        CDC_POS_CONV_REF = 2'b01,
        CDC_POS_FIXED_REF = 2'b10,
        CDC_POS_GROUND = 2'b11
    } cdc_pos_sel_t;
    typedef struct packed {
        logic enable;
        logic speed_power;
        logic hysteresis;
        cdc_pos_sel_t pos_select;
        logic [1:0] neg_select;
    } cdc_analog_ctl_t;
endpackage

// [core/cdc_comparator_ctrl.sv]
`timescale 1ns/1ps
// Operation
// - enable bit 7 of control 0 turns the comparator on
// - result bit 6 reads one when positive input exceeds negative, polarity applied
// - pin drive bit 5 routes result to pin when direction bit clear
// - invert bit 4 inverts the comparator result
// - speed/power bit 2 resets to one; zero selects low power
// - hysteresis bit 1 enables comparator hysteresis
// - sync bit 0 updates timer and pin output on timer clock falling edge
// - sync zero passes result to timer and pin without timer sampling
// - rise enable bit 7 of control 1 lets rising result set flag
// - fall enable bit 6 of control 1 lets falling result set flag
// - positive select bits 5-4: pin, converter ref, fixed ref, ground
// - negative select bits 1-0 pick one of four shared pins
// - mirror register shows second result bit 1, first bit 0, rest zero
// - control 0 bit 3 and control 1 bits 3-2 read zero
// - port reads return zero for analog-configured pins
// - software clears flag; a simultaneous new edge keeps it set
// - internal result latched each cycle; pin only latched when synchronised
// - toggling invert or enable can create an edge and set flag
module cdc_comparator_ctrl (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog comparators
    input wire logic [1:0] raw_compare,
    output cdc_pkg::cdc_analog_ctl_t [1:0] analog_ctl,
    // timer clock source and outputs
    input wire logic timer_clk_src,
    output logic [1:0] timer_result,
    // output pins
    input wire logic [1:0] pin_direction_bit,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic [1:0] irq_flag,
    // port read masking
    input wire logic [7:0] port_pins,
    input wire logic [7:0] analog_select,
    output logic [7:0] port_read
);
    import cdc_pkg::*;

    // ****************************************
    // register file
    // ****************************************
    logic [7:0] ctrl0 [2];
    logic [7:0] ctrl1 [2];
    logic [1:0] cmp_irq_flag;
    logic [1:0] cmp_result;
    logic [1:0] result_prev;
    logic [1:0] raw_s1;
    logic [1:0] raw_s2;
    logic [1:0] tclk_s;
    logic tclk_s2;
    logic [1:0] sync_result;
    logic [7:0] port_s1;
    logic [7:0] port_s2;
    logic [1:0] set_pulse;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] next_prdata;

    // ****************************************
    // address decoding
    // ****************************************
    function automatic logic [7:0] ctrl0_addr(input int idx);
        ctrl0_addr = (idx == 0) ? CDC_ADDR_CTRL0_C1 : CDC_ADDR_CTRL0_C2;
    endfunction

    function automatic logic [7:0] ctrl1_addr(input int idx);
        ctrl1_addr = (idx == 0) ? CDC_ADDR_CTRL1_C1 : CDC_ADDR_CTRL1_C2;
    endfunction

    // control 0 as read back: latched result cmp_result in place of the stored bit 6
    function automatic logic [7:0] ctrl0_view(input logic [7:0] c, input logic res);
        ctrl0_view = {c[7], res, c[5:0]};
    endfunction

    function automatic logic is_addr(input logic [7:0] a);
        is_addr = (a == CDC_ADDR_CTRL0_C1) || (a == CDC_ADDR_CTRL1_C1)
            || (a == CDC_ADDR_CTRL0_C2) || (a == CDC_ADDR_CTRL1_C2)
            || (a == CDC_ADDR_MIRROR) || (a == CDC_ADDR_FLAGS);
    endfunction

    assign addr_ok = is_addr(paddr);
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // ****************************************
    // control registers, one writer each
    // ****************************************
    genvar r;
    generate
        for (r = 0; r < 2; r++)
        begin : g_reg
            logic hit0;
            logic hit1;
            assign hit0 = wr_en && (paddr == ctrl0_addr(r));
            assign hit1 = wr_en && (paddr == ctrl1_addr(r));

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ctrl0[r] <= CDC_RST_CTRL0;
                else if (hit0)
                    ctrl0[r] <= pwdata[7:0] & CDC_WMASK_CTRL0;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ctrl1[r] <= CDC_RST_CTRL1;
                else if (hit1)
                    ctrl1[r] <= pwdata[7:0] & CDC_WMASK_CTRL1;
            end
        end
    endgenerate

    // ****************************************
    // read path
    // ****************************************
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            CDC_ADDR_CTRL0_C1: next_prdata[7:0] = ctrl0_view(ctrl0[0], cmp_result[0]);
            CDC_ADDR_CTRL1_C1: next_prdata[7:0] = ctrl1[0];
            CDC_ADDR_CTRL0_C2: next_prdata[7:0] = ctrl0_view(ctrl0[1], cmp_result[1]);
            CDC_ADDR_CTRL1_C2: next_prdata[7:0] = ctrl1[1];
            CDC_ADDR_MIRROR: next_prdata[1:0] = cmp_result;
            CDC_ADDR_FLAGS: next_prdata[1:0] = cmp_irq_flag;
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // read data registered in the setup cycle, valid in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
            prdata <= next_prdata;
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_s1 <= 2'h0;
            raw_s2 <= 2'h0;
        end
        else
        begin
            raw_s1 <= raw_compare;
            raw_s2 <= raw_s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tclk_s <= 2'h0;
            tclk_s2 <= 1'b0;
        end
        else
        begin
            tclk_s <= {tclk_s[0], timer_clk_src};
            tclk_s2 <= tclk_s[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_s1 <= 8'h00;
            port_s2 <= 8'h00;
        end
        else
        begin
            port_s1 <= port_pins;
            port_s2 <= port_s1;
        end
    end

    // ****************************************
    // per comparator output logic
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_cmp
            logic masked_raw;
            logic live_result;
            assign masked_raw = raw_s2[i] & ctrl0[i][CDC_B_ENABLE];
            assign live_result = masked_raw ^ ctrl0[i][CDC_B_INVERT];

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cmp_result[i] <= 1'b0;
                else
                    cmp_result[i] <= live_result;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    result_prev[i] <= 1'b0;
                else
                    result_prev[i] <= cmp_result[i];
            end

            // latched only on a falling edge of the synchronised timer clock
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    sync_result[i] <= 1'b0;
                else if (tclk_s2 && !tclk_s[1])
                    sync_result[i] <= live_result;
            end

            assign set_pulse[i] =
                (ctrl1[i][CDC_B_RISE_EN] && cmp_result[i] && !result_prev[i])
                || (ctrl1[i][CDC_B_FALL_EN] && !cmp_result[i] && result_prev[i]);

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cmp_irq_flag[i] <= 1'b0;
                else if (set_pulse[i])
                    cmp_irq_flag[i] <= 1'b1;
                else if (wr_en && paddr == CDC_ADDR_FLAGS && pwdata[i])
                    cmp_irq_flag[i] <= 1'b0;
            end

            // unsynchronised path is the live result, not latched
            assign timer_result[i] = ctrl0[i][CDC_B_SYNC] ? sync_result[i]
                : live_result;
            assign pin_out[i] = timer_result[i];
            assign pin_oe[i] = ctrl0[i][CDC_B_PIN_DRIVE] && !pin_direction_bit[i];

            assign analog_ctl[i].enable = ctrl0[i][CDC_B_ENABLE];
            assign analog_ctl[i].speed_power = ctrl0[i][CDC_B_SPEED];
            assign analog_ctl[i].hysteresis = ctrl0[i][CDC_B_HYST];
            assign analog_ctl[i].pos_select =
                cdc_pos_sel_t'(ctrl1[i][CDC_B_POS_LO +: 2]);
            assign analog_ctl[i].neg_select = ctrl1[i][CDC_B_NEG_LO +: 2];
        end
    endgenerate

    assign irq_flag = cmp_irq_flag;

    // ****************************************
    // port read masking
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_read <= 8'h00;
        else
            port_read <= port_s2 & ~analog_select;
    end
endmodule

// [testbench/cdc_comparator_ctrl_chk.sv]
`timescale 1ns/1ps
module cdc_comparator_ctrl_chk (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // outputs and pins
    input wire logic [1:0] timer_result,
    input wire logic [1:0] pin_direction_bit,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] irq_flag,
    input wire logic [7:0] port_pins,
    input wire logic [7:0] analog_select,
    input wire logic [7:0] port_read
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error response outside access phase");
    chk_err_unmapped: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (psel && penable && paddr[1:0] == 2'h0
        && paddr <= 8'h14 |-> !pslverr) else $error("mapped access refused");
    chk_oe_direction: assert property ((pin_oe & pin_direction_bit) == 2'h0)
        else $error("pin driven while set as input");
    chk_pin_timer: assert property (pin_out == timer_result)
        else $error("pin and timer results differ");
    chk_port_mask: assert property (port_read == ($past(port_pins, 3) & ~$past(analog_select)))
        else $error("port read value wrong");
    chk_flag_clear: assert property ($fell(irq_flag[0]) |-> $past(psel && penable && pwrite
        && paddr == 8'h14 && pwdata[0])) else $error("flag dropped without clear");
    chk_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
endmodule
bind cdc_comparator_ctrl cdc_comparator_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pslverr, .timer_result, .pin_direction_bit, .pin_out,
    .pin_oe, .irq_flag, .port_pins, .analog_select, .port_read);

// [testbench/test_cdc_comparator_ctrl.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module test_cdc_comparator_ctrl;
    import cdc_pkg::*;
    // ****************************************
    // signals and design
    // ****************************************
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic timer_clk_src = 1'h1, pready, pslverr, err;
    logic [7:0] paddr = 8'h00, port_pins = 8'h00, analog_select = 8'h00, port_read;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [1:0] raw_compare = 2'h0, pin_direction_bit = 2'h0, timer_result, pin_out, pin_oe;
    logic [1:0] irq_flag;
    cdc_analog_ctl_t [1:0] analog_ctl;
    int fail_count = 0, num_checks = 0;
    always #50 pclk = ~pclk;
    cdc_comparator_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .raw_compare, .analog_ctl, .timer_clk_src, .timer_result,
        .pin_direction_bit, .pin_out, .pin_oe, .irq_flag, .port_pins, .analog_select, .port_read);
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, a, d);
        repeat (6) @(posedge pclk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reg();
        apb(1'h0, CDC_ADDR_CTRL0_C1, 8'h00);
        `CHK("ctrl0 reset", 32'h0000_0004, rd)
        wr(CDC_ADDR_CTRL0_C1, 8'hFF);
        apb(1'h0, CDC_ADDR_CTRL0_C1, 8'h00);
        `CHK("ctrl0 bits", 32'h0000_00F7, rd)
        `CHK("enable", 1'h1, analog_ctl[0].enable)
        `CHK("hysteresis", 1'h1, analog_ctl[0].hysteresis)
        `CHK("pin drive", 2'h1, pin_oe)
        `CHK("sync held", 2'h0, timer_result)
        timer_clk_src <= 1'h0;
        repeat (6) @(posedge pclk);
        `CHK("sync update", 2'h1, pin_out)
        pin_direction_bit <= 2'h1;
        @(posedge pclk);
        `CHK("pin input", 2'h0, pin_oe)
        for (int k = 0; k < 4; k++)
        begin
            wr(CDC_ADDR_CTRL1_C2, 8'(k * 17));
            `CHK("pos sel", cdc_pos_sel_t'(k), analog_ctl[1].pos_select)
            `CHK("neg sel", 2'(k), analog_ctl[1].neg_select)
        end
        wr(CDC_ADDR_CTRL1_C1, 8'hFF);
        apb(1'h0, CDC_ADDR_CTRL1_C1, 8'h00);
        `CHK("ctrl1 bits", 32'h0000_00F3, rd)
        $display("test reg done");
    endtask
    task automatic t_result();
        wr(CDC_ADDR_CTRL0_C1, 8'h80);
        raw_compare <= 2'h1;
        repeat (6) @(posedge pclk);
        apb(1'h0, CDC_ADDR_CTRL0_C1, 8'h00);
        `CHK("result", 32'h0000_00C0, rd)
        apb(1'h0, CDC_ADDR_MIRROR, 8'h00);
        `CHK("mirror", 32'h0000_0001, rd)
        `CHK("async out", 2'h1, timer_result)
        wr(CDC_ADDR_CTRL0_C1, 8'h90);
        apb(1'h0, CDC_ADDR_CTRL0_C1, 8'h00);
        `CHK("inverted", 32'h0000_0090, rd)
        $display("test result done");
    endtask
    task automatic t_irq();
        wr(CDC_ADDR_CTRL1_C1, 8'h80);
        wr(CDC_ADDR_FLAGS, 8'h03);
        wr(CDC_ADDR_CTRL0_C1, 8'h00);
        `CHK("forced low", 2'h0, irq_flag)
        wr(CDC_ADDR_CTRL0_C1, 8'h10);
        `CHK("rise flag", 2'h1, irq_flag)
        wr(CDC_ADDR_FLAGS, 8'h01);
        `CHK("cleared", 2'h0, irq_flag)
        wr(CDC_ADDR_CTRL0_C1, 8'h00);
        `CHK("fall off", 2'h0, irq_flag)
        wr(CDC_ADDR_CTRL1_C1, 8'h40);
        wr(CDC_ADDR_CTRL0_C1, 8'h10);
        `CHK("rise off", 2'h0, irq_flag)
        wr(CDC_ADDR_CTRL0_C1, 8'h00);
        `CHK("fall flag", 2'h1, irq_flag)
        $display("test irq done");
    endtask
    task automatic t_race();
        wr(CDC_ADDR_CTRL1_C1, 8'h80);
        raw_compare <= 2'h0;
        wr(CDC_ADDR_CTRL0_C1, 8'h80);
        wr(CDC_ADDR_FLAGS, 8'h03);
        raw_compare <= 2'h1;
        repeat (2) @(posedge pclk);
        apb(1'h1, CDC_ADDR_FLAGS, 8'h01);
        `CHK("set wins", 2'h1, irq_flag)
        $display("test race done");
    endtask
    task automatic t_port();
        port_pins <= 8'hA5;
        analog_select <= 8'h0F;
        repeat (4) @(posedge pclk);
        `CHK("port read", 8'hA0, port_read)
        apb(1'h0, 8'h20, 8'h00);
        `CHK("unmapped", 33'h0_0000_0001, {rd, err})
        $display("test port done");
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reg();
        t_result();
        t_irq();
        t_race();
        t_port();
        summarize();
    end
    initial
    begin
        #1ms;
        fail_count++;
        summarize();
    end
endmodule
